// ### hdl/oms_top.sv
// operation mode switch logic with axi4-lite settings port
`timescale 1ns/1ps
// Overview of operation
// - with selections 0,2,7 network moves only while stopped, except 7 forcing external.
// - selection 6 accepts mode changes while running, operation continues.
// - network/panel input asserted selects panel, deasserted selects network.
// - selection 7 switches only with interlock on, else forced external.
// - startup 10, selection 0, net_pu assigned: panel or network only, never external.
// - selection 1 fixed panel; selection 2 with startup 10 fixed network.
// - selections 3 and 4 fixed combined mode, network inputs ignored.
// - network/external asserted overrides a panel request to network.
// - pu_ext_switch deasserted turns network or external into panel.
// - command source 0 without option fitted turns network into panel.
// - selection 7, interlock on, startup 10, net_pu off: pu_ext gives external.
// - network/external input asserted selects network, deasserted external.
// - selection 2 toggles network and external only, never panel.
// - net_ext deasserted with net_pu assigned lets net_pu decide.
// - priority: selection, interlock, net_ext, net_pu, pu_ext, startup.
// - selection 7 with interlock on stops output in external mode.
// - startup defaults 0; 1 and 10 start network; 10 allows panel changes.
module oms_top (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	// axi4-lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// input terminals
	input  wire logic [3:0]  term_in,
	// drive status
	input  wire logic        motor_running,
	input  wire logic        start_cmd,
	input  wire logic        option_fitted,
	// resolved mode
	output logic [1:0]       op_mode,
	output logic             output_stop_input
);

	// settings registers
	logic [31:0]        cfg_q, cfg_d;
	logic [31:0]        assign_q, assign_d;
	oms_pkg::oms_mode_e mode_q, mode_d;
	logic               stop_q, stop_d;

	// axi state
	logic               aw_hold_q, aw_hold_d;
	logic               w_hold_q, w_hold_d;
	logic [7:0]         awaddr_q, awaddr_d;
	logic [31:0]        wdata_q, wdata_d;
	logic [3:0]         wstrb_q, wstrb_d;
	logic               bvalid_q, bvalid_d;
	logic [1:0]         bresp_q, bresp_d;
	logic               rvalid_q, rvalid_d;
	logic [31:0]        rdata_q, rdata_d;
	logic [1:0]         rresp_q, rresp_d;

	// switching input decode
	logic [3:0]         func_hit [4];
	logic               net_pu_switch, net_ext_switch, pu_interlock, pu_ext_switch;
	logic               net_pu_present, net_ext_present, pu_interlock_present, pu_ext_present;
	oms_pkg::oms_mode_e target_mode;
	logic               free_switch;
	logic               stopped;
	logic [3:0]         opsel;

	// terminal code of one 8-bit assignment slot
	function automatic logic [6:0] slot_code(input logic [31:0] a, input int idx);
		slot_code = a[idx*8 +: 7];
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < oms_pkg::OMS_NUM_TERM; gi++) begin : g_term
			assign func_hit[0][gi] = (slot_code(assign_q, gi) == oms_pkg::OMS_FUNC_NET_PU);
			assign func_hit[1][gi] = (slot_code(assign_q, gi) == oms_pkg::OMS_FUNC_NET_EXT);
			assign func_hit[2][gi] = (slot_code(assign_q, gi) == oms_pkg::OMS_FUNC_INTLK);
			assign func_hit[3][gi] = (slot_code(assign_q, gi) == oms_pkg::OMS_FUNC_PU_EXT);
		end
	endgenerate

	always_comb begin
		net_pu_present       = |func_hit[0];
		net_ext_present      = |func_hit[1];
		pu_interlock_present = |func_hit[2];
		pu_ext_present       = |func_hit[3];
		net_pu_switch        = |(func_hit[0] & term_in);
		net_ext_switch       = |(func_hit[1] & term_in);
		pu_interlock         = |(func_hit[2] & term_in);
		pu_ext_switch        = |(func_hit[3] & term_in);
		opsel                = cfg_q[oms_pkg::OMS_CFG_OPSEL_LSB +: 4];
	end

	oms_resolve u_resolve (
		.op_mode_select       (opsel),
		.startup_mode_select  (cfg_q[oms_pkg::OMS_CFG_START_LSB +: 4]),
		.net_cmd_source_zero  (cfg_q[oms_pkg::OMS_CFG_CMDSRC_LSB +: 2] == 2'h0),
		.option_fitted        (option_fitted),
		.net_pu_switch        (net_pu_switch),
		.net_pu_present       (net_pu_present),
		.net_ext_switch       (net_ext_switch),
		.net_ext_present      (net_ext_present),
		.pu_interlock         (pu_interlock),
		.pu_interlock_present (pu_interlock_present),
		.pu_ext_switch        (pu_ext_switch),
		.pu_ext_present       (pu_ext_present),
		.target_mode          (target_mode),
		.free_switch          (free_switch)
	);

	// mode register
	always_comb begin
		stopped = !motor_running || !start_cmd;
		mode_d  = mode_q;
		if (opsel == oms_pkg::OMS_OPSEL_7 && pu_interlock_present && !pu_interlock) begin
			mode_d = oms_pkg::OMS_EXT;
		// change only while stopped unless free
		end else if (stopped || free_switch) begin
			mode_d = target_mode;
		end
		// output stop in external under interlock
		stop_d = (opsel == oms_pkg::OMS_OPSEL_7) && (!pu_interlock_present || pu_interlock)
			&& (mode_d == oms_pkg::OMS_EXT);
	end

	// axi4-lite slave
	always_comb begin
		aw_hold_d = aw_hold_q;
		w_hold_d  = w_hold_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		cfg_d     = cfg_q;
		assign_d  = assign_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
		end
		if (aw_hold_q && w_hold_q && !bvalid_q) begin
			aw_hold_d = 1'b0;
			w_hold_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = oms_pkg::OMS_RESP_OKAY;
			if (awaddr_q == oms_pkg::OMS_ADDR_CFG) begin
				for (int i = 0; i < 4; i++) begin
					if (wstrb_q[i]) begin
						cfg_d[i*8 +: 8] = wdata_q[i*8 +: 8];
					end
				end
			end else if (awaddr_q == oms_pkg::OMS_ADDR_ASSIGN) begin
				for (int i = 0; i < 4; i++) begin
					if (wstrb_q[i]) begin
						assign_d[i*8 +: 8] = wdata_q[i*8 +: 8];
					end
				end
			end else if (awaddr_q != oms_pkg::OMS_ADDR_STATUS) begin
				bresp_d = oms_pkg::OMS_RESP_SLVERR;
			end
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d  = oms_pkg::OMS_RESP_OKAY;
			if (s_axi_araddr == oms_pkg::OMS_ADDR_CFG) begin
				rdata_d = cfg_q;
			end else if (s_axi_araddr == oms_pkg::OMS_ADDR_ASSIGN) begin
				rdata_d = assign_q;
			end else if (s_axi_araddr == oms_pkg::OMS_ADDR_STATUS) begin
				rdata_d = {23'h0, stopped, stop_q, term_in, 1'b0, mode_q};
			end else begin
				rdata_d = 32'h0000_0000;
				rresp_d = oms_pkg::OMS_RESP_SLVERR;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q     <= oms_pkg::OMS_CFG_RST;
			assign_q  <= oms_pkg::OMS_ASSIGN_RST;
			mode_q    <= oms_pkg::OMS_EXT;
			stop_q    <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= 2'h0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= 2'h0;
		end else begin
			cfg_q     <= cfg_d;
			assign_q  <= assign_d;
			mode_q    <= mode_d;
			stop_q    <= stop_d;
			aw_hold_q <= aw_hold_d;
			w_hold_q  <= w_hold_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	always_comb begin
		s_axi_awready     = !aw_hold_q;
		s_axi_wready      = !w_hold_q;
		s_axi_arready     = !rvalid_q;
		s_axi_bvalid      = bvalid_q;
		s_axi_bresp       = bresp_q;
		s_axi_rvalid      = rvalid_q;
		s_axi_rdata       = rdata_q;
		s_axi_rresp       = rresp_q;
		op_mode           = mode_q;
		output_stop_input = stop_q;
	end

endmodule

// ### hdl/oms_pkg.sv
// constants and types for the operation mode switch logic
package oms_pkg;

	// resolved operation modes, gray-coded along panel/net/ext
	typedef enum logic [1:0] {
		OMS_PANEL = 2'h0,
		OMS_NET   = 2'h1,
		OMS_EXT   = 2'h3,
		OMS_COMB  = 2'h2
	} oms_mode_e;

	// op_mode_select values
	localparam logic [3:0] OMS_OPSEL_0 = 4'h0;
	localparam logic [3:0] OMS_OPSEL_1 = 4'h1;
	localparam logic [3:0] OMS_OPSEL_2 = 4'h2;
	localparam logic [3:0] OMS_OPSEL_3 = 4'h3;
	localparam logic [3:0] OMS_OPSEL_4 = 4'h4;
	localparam logic [3:0] OMS_OPSEL_6 = 4'h6;
	localparam logic [3:0] OMS_OPSEL_7 = 4'h7;

	// startup_mode_select values
	localparam logic [3:0] OMS_START_0  = 4'h0;
	localparam logic [3:0] OMS_START_1  = 4'h1;
	localparam logic [3:0] OMS_START_10 = 4'hA;

	// input terminal function codes
	localparam logic [6:0] OMS_FUNC_NET_PU  = 7'h41;
	localparam logic [6:0] OMS_FUNC_NET_EXT = 7'h42;
	localparam logic [6:0] OMS_FUNC_INTLK   = 7'h0C;
	localparam logic [6:0] OMS_FUNC_PU_EXT  = 7'h10;

	// register map (byte addresses)
	localparam logic [7:0] OMS_ADDR_CFG    = 8'h00;
	localparam logic [7:0] OMS_ADDR_ASSIGN = 8'h04;
	localparam logic [7:0] OMS_ADDR_STATUS = 8'h08;

	// reset values
	localparam logic [31:0] OMS_CFG_RST    = 32'h0000_0000;
	localparam logic [31:0] OMS_ASSIGN_RST = 32'h0000_0000;

	// field positions in the cfg register
	localparam int OMS_CFG_OPSEL_LSB  = 0;
	localparam int OMS_CFG_START_LSB  = 4;
	localparam int OMS_CFG_CMDSRC_LSB = 8;

	// number of input terminals
	localparam int OMS_NUM_TERM = 4;

	localparam logic [1:0] OMS_RESP_OKAY   = 2'h0;
	localparam logic [1:0] OMS_RESP_SLVERR = 2'h2;

endpackage

// ### hdl/oms_resolve.sv
// combinational mode resolver for the operation mode switch
`timescale 1ns/1ps
module oms_resolve (
	// settings
	input  wire logic [3:0]        op_mode_select,
	input  wire logic [3:0]        startup_mode_select,
	input  wire logic              net_cmd_source_zero,
	input  wire logic              option_fitted,
	// switching inputs and their presence
	input  wire logic              net_pu_switch,
	input  wire logic              net_pu_present,
	input  wire logic              net_ext_switch,
	input  wire logic              net_ext_present,
	input  wire logic              pu_interlock,
	input  wire logic              pu_interlock_present,
	input  wire logic              pu_ext_switch,
	input  wire logic              pu_ext_present,
	// result
	output oms_pkg::oms_mode_e     target_mode,
	output logic                   free_switch
);

	// network chosen on command source 0 but option missing falls back to panel
	function automatic oms_pkg::oms_mode_e net_or_panel(input logic cmd0, input logic fitted);
		net_or_panel = (cmd0 && !fitted) ? oms_pkg::OMS_PANEL : oms_pkg::OMS_NET;
	endfunction

	// panel/external by pu_ext_switch, absent input means external
	function automatic oms_pkg::oms_mode_e ext_or_panel(input logic pres, input logic sw);
		ext_or_panel = (pres && !sw) ? oms_pkg::OMS_PANEL : oms_pkg::OMS_EXT;
	endfunction

	logic intlk_on;
	logic start10;

	always_comb begin
		intlk_on    = !pu_interlock_present || pu_interlock;
		start10     = (startup_mode_select == oms_pkg::OMS_START_10);
		free_switch = (op_mode_select == oms_pkg::OMS_OPSEL_6);
		target_mode = oms_pkg::OMS_EXT;
		case (op_mode_select)
			oms_pkg::OMS_OPSEL_1: target_mode = oms_pkg::OMS_PANEL;
			oms_pkg::OMS_OPSEL_3, oms_pkg::OMS_OPSEL_4: target_mode = oms_pkg::OMS_COMB;
			default: begin
				if (op_mode_select == oms_pkg::OMS_OPSEL_7 && !intlk_on) begin
					target_mode = oms_pkg::OMS_EXT;
				end else if (op_mode_select == oms_pkg::OMS_OPSEL_2 && start10) begin
					target_mode = net_or_panel(net_cmd_source_zero, option_fitted);
				end else if (net_ext_present && net_ext_switch) begin
					target_mode = net_or_panel(net_cmd_source_zero, option_fitted);
				end else if (net_pu_present && (start10 || net_ext_present)
					&& op_mode_select != oms_pkg::OMS_OPSEL_2) begin
					if (net_pu_switch) begin
						target_mode = oms_pkg::OMS_PANEL;
					end else if (pu_ext_present && op_mode_select == oms_pkg::OMS_OPSEL_7) begin
						target_mode = pu_ext_switch ? oms_pkg::OMS_EXT : oms_pkg::OMS_PANEL;
					end else if (pu_ext_present && !pu_ext_switch) begin
						target_mode = oms_pkg::OMS_PANEL;
					end else begin
						target_mode = net_or_panel(net_cmd_source_zero, option_fitted);
					end
				end else if (op_mode_select == oms_pkg::OMS_OPSEL_2) begin
					target_mode = oms_pkg::OMS_EXT;
				end else if (pu_ext_present) begin
					target_mode = ext_or_panel(pu_ext_present, pu_ext_switch);
				end else if (startup_mode_select == oms_pkg::OMS_START_1 || start10) begin
					target_mode = net_or_panel(net_cmd_source_zero, option_fitted);
				end else begin
					target_mode = oms_pkg::OMS_EXT;
				end
			end
		endcase
	end

endmodule

// ### sim/oms_chk_assertions.sv
// checker for the operation mode switch logic
`timescale 1ns/1ps
module oms_chk (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// register write
	input  wire logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	// terminals and drive
	input  wire logic [3:0]  term_in,
	input  wire logic        motor_running,
	input  wire logic        start_cmd,
	input  wire logic        option_fitted,
	// mode
	input  wire logic [1:0]  op_mode,
	input  wire logic        output_stop_input
);
	logic [9:0]  cfg_q;
	logic [31:0] asg_q;
	logic [2:0]  age_q;
	logic [1:0]  np, ne, il, pe;
	logic [3:0]  sel, st;
	logic        wt, run, rdy, ilon, peok, optok;
	logic [6:0]  in_q;
	logic        chg, settled;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	assign wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign run = motor_running && start_cmd;
	// inputs that moved at this edge are not yet in op_mode
	assign chg = {term_in, motor_running, start_cmd, option_fitted} != in_q;
	assign settled = age_q >= 3'h3 && !chg;
	assign rdy = settled && !run;
	assign sel = cfg_q[3:0];
	assign st = cfg_q[7:4];
	assign ilon = !il[1] || il[0];
	assign peok = !pe[1] || pe[0];
	assign optok = option_fitted || cfg_q[9:8] != 2'h0;
	always_ff @(posedge aclk) begin
		in_q <= {term_in, motor_running, start_cmd, option_fitted};
	end
	// shadow of settings, age since last write or input change
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q <= '0;
			asg_q <= '0;
			age_q <= '0;
		end else begin
			if (wt && s_axi_awaddr == oms_pkg::OMS_ADDR_CFG) cfg_q <= s_axi_wdata[9:0];
			if (wt && s_axi_awaddr == oms_pkg::OMS_ADDR_ASSIGN) asg_q <= s_axi_wdata;
			if (wt || chg) age_q <= '0;
			else if (age_q != 3'h7) age_q <= age_q + 3'h1;
		end
	end
	// unassigned functions read as absent
	always_comb begin
		np = '0;
		ne = '0;
		il = '0;
		pe = '0;
		for (int i = 0; i < 4; i++) begin
			if (asg_q[i*8+:7] == oms_pkg::OMS_FUNC_NET_PU) np = {1'b1, term_in[i]};
			if (asg_q[i*8+:7] == oms_pkg::OMS_FUNC_NET_EXT) ne = {1'b1, term_in[i]};
			if (asg_q[i*8+:7] == oms_pkg::OMS_FUNC_INTLK) il = {1'b1, term_in[i]};
			if (asg_q[i*8+:7] == oms_pkg::OMS_FUNC_PU_EXT) pe = {1'b1, term_in[i]};
		end
	end
	a_panel_fixed: assert property (rdy && sel == 4'h1 |-> op_mode == 2'h0)
		else $error("panel mode expected");
	a_net_fixed: assert property (rdy && sel == 4'h2 && st == 4'hA && optok |-> op_mode == 2'h1)
		else $error("network mode expected");
	a_comb_fixed: assert property (rdy && (sel == 4'h3 || sel == 4'h4) |-> op_mode == 2'h2)
		else $error("combined mode expected");
	a_intlk_force: assert property (settled && sel == 4'h7 && !ilon |-> op_mode == 2'h3 && !output_stop_input)
		else $error("external mode expected with interlock off");
	a_ext_stop: assert property (settled && sel == 4'h7 && ilon |-> output_stop_input == (op_mode == 2'h3))
		else $error("output stop mismatch");
	a_netpu_pick: assert property (rdy && sel == 4'h0 && st == 4'hA && optok && np[1] && ne != 2'h3 && peok
		|-> op_mode == (np[0] ? 2'h0 : 2'h1))
		else $error("panel/network choice wrong");
	a_netext_pick: assert property (rdy && sel == 4'h0 && st == 4'h0 && optok && ne[1] && !np[1] && peok
		|-> op_mode == (ne[0] ? 2'h1 : 2'h3))
		else $error("network/external choice wrong");
	a_ext_override: assert property (rdy && sel == 4'h0 && optok && peok && ne == 2'h3 |-> op_mode == 2'h1)
		else $error("network expected with net_ext on");
	a_no_option: assert property (rdy && sel == 4'h0 && st == 4'hA && !optok |-> op_mode != 2'h1)
		else $error("network without option");
	a_run_hold: assert property (run && $past(run) && $past(run, 2) && sel != 4'h6 && sel != 4'h7
		|-> $stable(op_mode))
		else $error("mode changed while running");
endmodule
bind oms_top oms_chk oms_chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
	.s_axi_wready, .s_axi_wdata, .term_in, .motor_running, .start_cmd, .option_fitted, .op_mode, .output_stop_input);

// ### sim/oms_term_model.sv
// control terminals and drive status seen by the block
`timescale 1ns/1ps
module oms_term_model (
	// clock
	input  wire logic       aclk,
	// requested levels
	input  wire logic [3:0] level_req,
	input  wire logic       run_req,
	input  wire logic       start_req,
	// to the block
	output logic [3:0]      term_in,
	output logic            motor_running,
	output logic            start_cmd
);
	// terminal i carries the function assigned to slot i
	always_ff @(posedge aclk) begin
		term_in       <= level_req;
		motor_running <= run_req;
		start_cmd     <= start_req;
	end
endmodule

// ### sim/tb_operation_mode_switch_logic.sv
// testbench for the operation mode switch logic
`timescale 1ns/1ps
module tb_operation_mode_switch_logic;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, output_stop_input;
	logic        option_fitted, run_req, start_req, motor_running, start_cmd;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0]  s_axi_bresp, s_axi_rresp, op_mode, r;
	logic [3:0]  term_in, level_req;
	int          n_fail, checks, cyc;
	oms_top oms_top_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .term_in, .motor_running, .start_cmd, .option_fitted, .op_mode,
		.output_stop_input);
	oms_term_model oms_term_model_i (.aclk, .level_req, .run_req, .start_req, .term_in, .motor_running, .start_cmd);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic wrap_up;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			wrap_up;
		end
	end
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// levels {pu_ext, interlock, net_ext, net_pu}, then let model and block settle
	task automatic step(input logic [3:0] lv, input logic mr, input logic sc);
		level_req <= lv;
		run_req   <= mr;
		start_req <= sc;
		repeat (4) @(posedge aclk);
	endtask
	task automatic chm(input logic [1:0] e);
		cmp({30'h0, op_mode}, {30'h0, e});
	endtask
	// cfg is {source, startup, selection}
	task automatic tc(input logic [9:0] c, input logic [3:0] lv, input logic opt, input logic [1:0] e);
		wr(oms_pkg::OMS_ADDR_CFG, {22'h0, c}, r);
		option_fitted <= opt;
		step(lv, run_req, start_req);
		chm(e);
	endtask
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, run_req, start_req} = '0;
		{n_fail, checks, cyc} = '0;
		level_req = 4'h0;
		option_fitted = 1'b1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		chm(oms_pkg::OMS_EXT);
		rd(oms_pkg::OMS_ADDR_CFG, d, r);
		cmp(d, oms_pkg::OMS_CFG_RST);
		rd(8'h0C, d, r);
		cmp({30'h0, r}, {30'h0, oms_pkg::OMS_RESP_SLVERR});
		wr(8'h10, 32'hFFFF_FFFF, r);
		cmp({30'h0, r}, {30'h0, oms_pkg::OMS_RESP_SLVERR});
		wr(oms_pkg::OMS_ADDR_STATUS, 32'hFFFF_FFFF, r);
		cmp({30'h0, r}, {30'h0, oms_pkg::OMS_RESP_OKAY});
		tc(10'h110, 4'hF, 1'b1, oms_pkg::OMS_NET);
		tc(10'h100, 4'hF, 1'b1, oms_pkg::OMS_EXT);
		// slot 0 unassigned, net_ext, interlock, pu_ext on terminals 1..3
		wr(oms_pkg::OMS_ADDR_ASSIGN, 32'h100C_4200, r);
		tc(10'h100, 4'hC, 1'b1, oms_pkg::OMS_EXT);
		tc(10'h100, 4'hE, 1'b1, oms_pkg::OMS_NET);
		tc(10'h102, 4'hE, 1'b1, oms_pkg::OMS_NET);
		tc(10'h102, 4'hC, 1'b1, oms_pkg::OMS_EXT);
		wr(oms_pkg::OMS_ADDR_ASSIGN, 32'h100C_4241, r);
		tc(10'h1A0, 4'hD, 1'b1, oms_pkg::OMS_PANEL);
		tc(10'h1A0, 4'hC, 1'b1, oms_pkg::OMS_NET);
		tc(10'h1A0, 4'hF, 1'b1, oms_pkg::OMS_NET);
		tc(10'h1A0, 4'h4, 1'b1, oms_pkg::OMS_PANEL);
		tc(10'h0A0, 4'hC, 1'b0, oms_pkg::OMS_PANEL);
		tc(10'h1A1, 4'hC, 1'b1, oms_pkg::OMS_PANEL);
		tc(10'h1A2, 4'hD, 1'b1, oms_pkg::OMS_NET);
		tc(10'h1A3, 4'hC, 1'b1, oms_pkg::OMS_COMB);
		tc(10'h1A4, 4'hF, 1'b1, oms_pkg::OMS_COMB);
		tc(10'h100, 4'hF, 1'b1, oms_pkg::OMS_NET);
		tc(10'h100, 4'hD, 1'b1, oms_pkg::OMS_PANEL);
		tc(10'h1A7, 4'h9, 1'b1, oms_pkg::OMS_EXT);
		cmp({31'h0, output_stop_input}, 32'h0);
		tc(10'h1A7, 4'hC, 1'b1, oms_pkg::OMS_EXT);
		cmp({31'h0, output_stop_input}, 32'h1);
		tc(10'h1A7, 4'hD, 1'b1, oms_pkg::OMS_PANEL);
		// held while running, applied once start drops
		tc(10'h1A0, 4'hD, 1'b1, oms_pkg::OMS_PANEL);
		step(4'hD, 1'b1, 1'b1);
		step(4'hC, 1'b1, 1'b1);
		chm(oms_pkg::OMS_PANEL);
		step(4'hC, 1'b1, 1'b0);
		chm(oms_pkg::OMS_NET);
		rd(oms_pkg::OMS_ADDR_STATUS, d, r);
		cmp({30'h0, d[1:0]}, {30'h0, oms_pkg::OMS_NET});
		// status word: stopped, no output stop, terminals C, network mode
		cmp(d, {23'h0, 1'b1, 1'b0, 4'hC, 1'b0, oms_pkg::OMS_NET});
		tc(10'h1A6, 4'hD, 1'b1, oms_pkg::OMS_PANEL);
		step(4'hD, 1'b1, 1'b1);
		step(4'hC, 1'b1, 1'b1);
		chm(oms_pkg::OMS_NET);
		step(4'h0, 1'b0, 1'b0);
		wrap_up;
	end
endmodule
